// ---- logic/adc_capture_pkg.sv ----
// Shared constants and types for the sampling converter capture block.
// Assumes a single system clock domain; no other package is needed.
package adc_capture_pkg;

  // Output word and pipeline shape.
  localparam int CODE_W     = 8;
  localparam int PIPE_DEPTH = 5;
  localparam int FIFO_DEPTH = 8;

  // Input span: the differential input is given in millivolts.
  localparam int FULL_SCALE_MV = 1000;
  localparam int CODE_MAX      = 255;

  // Characteristic output codes.
  localparam logic [7:0] CODE_TOP   = 8'hff;
  localparam logic [7:0] CODE_BOTTOM = 8'h00;
  localparam logic [7:0] CODE_MID_LO = 8'h7f;
  localparam logic [7:0] CODE_MID_HI = 8'h80;

  // Values after reset.
  localparam logic [7:0] CODE_RESET = 8'h00;

  // One converted result: range flag above the offset-binary code.
  typedef struct packed {
    logic                  flag;
    logic [CODE_W-1:0]     code;
  } sample_entry_s;

  localparam int ENTRY_W = CODE_W + 1;

endpackage

// ---- logic/sample_stream_if.sv ----
// Valid/ready stream carrying converted results between design modules.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sample_stream_if #(parameter int W = 9);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ---- logic/sample_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo
  import adc_capture_pkg::*;
#(
  parameter int W     = ENTRY_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic clk_sys,        // System clock.
  input  wire logic resetn,         // Synchronous reset, active low.
  sample_stream_if.snk fill,        // Write side.
  sample_stream_if.src drain        // Read side.
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
  } fifo_state_s;

  fifo_state_s st;
  fifo_state_s next_st;
  logic        do_push;
  logic        do_pop;

  // Handshake flags come straight from the occupancy count.
  assign fill.ready  = (st.count != (AW+1)'(DEPTH));
  assign drain.valid = (st.count != '0);
  assign drain.data  = st.mem[st.rd_ptr];
  assign do_push     = fill.valid && fill.ready;
  assign do_pop      = drain.valid && drain.ready;

  // Pointer and count update; pointers wrap at the depth.
  always_comb
  begin
    next_st = st;
    if (do_push)
    begin
      next_st.mem[st.wr_ptr] = fill.data;
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH-1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (do_pop)
    begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH-1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      next_st.count = st.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ---- logic/adc_sample_capture.sv ----
// Digital side of an 8-bit pipelined sampling converter.
// Assumes the conversion clock and all pins are synchronous to clk_sys
// and that the conversion clock runs well below half the clk_sys rate.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Each conversion clock falling edge starts conversion.
// - Power-down input low enters shutdown state.
// - Plus one volt gives the largest code.
// - Minus one volt gives the smallest code.
// - Offset binary, mid codes 7f and 80.
// - Result appears five conversion cycles after capture.
// - Range flag marks overrange or underrange.
// - Input tracked while clock high, held after.
module adc_sample_capture
  import adc_capture_pkg::*;
#(
  parameter int DW = 12
)(
  input  wire logic                 clk_sys,        // System clock.
  input  wire logic                 resetn,         // Sync reset, low.
  input  wire logic                 conv_clk,       // Conversion clock.
  input  wire logic                 power_down_n,   // Low: shutdown.
  input  wire logic signed [DW-1:0] input_positive, // Positive input, mV.
  input  wire logic signed [DW-1:0] input_negative, // Negative input, mV.
  output var  logic [CODE_W-1:0]    sample_word,    // Result code.
  output var  logic                 range_flag,     // Out of range.
  output logic                      sample_valid,   // Word is valid.
  input  wire logic                 sample_ready,   // Capture accepts word.
  output var  logic                 shutdown,       // Converter powered down.
  output var  logic                 overrun         // Result lost, FIFO full.
);

  typedef struct packed {
    logic                                 valid;
    sample_entry_s                        entry;
  } stage_s;

  typedef struct packed {
    logic                                 clk_prev;
    logic signed [DW-1:0]                 track;
    logic [PIPE_DEPTH-1:0][ENTRY_W:0]     pipe;
    logic [CODE_W-1:0]                    word;
    logic                                 flag;
    logic                                 out_valid;
    logic                                 down;
    logic                                 lost;
    logic [2:0]                           seen;
  } capture_state_s;

  capture_state_s     st;
  capture_state_s     next_st;
  logic signed [DW:0] diff;
  logic               fall;
  logic               live;
  stage_s             head;
  sample_entry_s      popped;

  sample_stream_if #(.W(ENTRY_W)) push_if ();
  sample_stream_if #(.W(ENTRY_W)) pop_if ();

  // Quantise a held differential voltage to an offset-binary word.
  function automatic sample_entry_s quantize(input logic signed [DW:0] v);
    sample_entry_s    r;
    logic signed [31:0] t;
    r = '0;
    t = 32'(v);
    if (t > FULL_SCALE_MV)
    begin
      r.flag = 1'b1;
      r.code = CODE_TOP;
    end
    else if (t < -FULL_SCALE_MV)
    begin
      r.flag = 1'b1;
      r.code = CODE_BOTTOM;
    end
    else
    begin
      t = ((t + FULL_SCALE_MV) * CODE_MAX) / (2 * FULL_SCALE_MV);
      r.code = CODE_W'(t);
    end
    return r;
  endfunction

  // Edge detection and the live differential input.
  assign diff = (DW+1)'(input_positive) - (DW+1)'(input_negative);
  assign fall = st.clk_prev && !conv_clk;
  assign live = power_down_n;
  assign head = stage_s'(st.pipe[PIPE_DEPTH-1]);
  assign popped = sample_entry_s'(pop_if.data);

  // The last pipeline stage feeds the FIFO on a conversion edge.
  assign push_if.valid = fall && live && head.valid;
  assign push_if.data  = head.entry;
  assign pop_if.ready  = !st.out_valid || sample_ready;

  // Conversion pipeline, tracking and output stage.
  always_comb
  begin
    next_st = st;
    next_st.clk_prev = conv_clk;
    next_st.down = !power_down_n;
    if (!live)
    begin
      next_st.pipe = '0;
      next_st.seen = '0;
    end
    else
    begin
      if (conv_clk)
      begin
        next_st.track = DW'(diff);
      end
      if (fall)
      begin
        next_st.pipe[0] = {1'b1, quantize((DW+1)'(st.track))};
        for (int i = 1; i < PIPE_DEPTH; i++)
        begin
          next_st.pipe[i] = st.pipe[i-1];
        end
        // Falls since the pipeline was last empty, saturating at its depth.
        if (st.seen != 3'(PIPE_DEPTH))
        begin
          next_st.seen = st.seen + 3'h1;
        end
      end
    end
    if (push_if.valid && !push_if.ready)
    begin
      next_st.lost = 1'b1;
    end
    if (pop_if.ready)
    begin
      next_st.out_valid = pop_if.valid;
      if (pop_if.valid)
      begin
        next_st.word = popped.code;
        next_st.flag = popped.flag;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  sample_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .fill    (push_if),
    .drain   (pop_if)
  );

  // Outputs from the state register.
  assign sample_word  = st.word;
  assign range_flag   = st.flag;
  assign sample_valid = st.out_valid;
  assign shutdown     = st.down;
  assign overrun      = st.lost;

  // Checks on the capture path.
  property p_capture;
    @(posedge clk_sys) disable iff (!resetn)
    fall && live |=> st.pipe[0][ENTRY_W];
  endproperty
  a_capture: assert property (p_capture) else $error("No capture.");

  property p_shutdown;
    @(posedge clk_sys) disable iff (!resetn)
    !power_down_n |=> shutdown && (st.pipe == '0) && !push_if.valid;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("Not down.");

  property p_top;
    @(posedge clk_sys) disable iff (!resetn)
    fall && live && st.track == DW'(FULL_SCALE_MV)
      |=> st.pipe[0][CODE_W-1:0] == CODE_TOP && !st.pipe[0][CODE_W];
  endproperty
  a_top: assert property (p_top) else $error("Bad top code.");

  property p_bottom;
    @(posedge clk_sys) disable iff (!resetn)
    fall && live && st.track == -DW'(FULL_SCALE_MV)
      |=> st.pipe[0][CODE_W-1:0] == CODE_BOTTOM && !st.pipe[0][CODE_W];
  endproperty
  a_bottom: assert property (p_bottom) else $error("Bad bottom code.");

  property p_mid;
    @(posedge clk_sys) disable iff (!resetn)
    fall && live && st.track == '0
      |=> st.pipe[0][CODE_W-1:0] == CODE_MID_LO;
  endproperty
  a_mid: assert property (p_mid) else $error("Bad mid code.");

  property p_latency;
    @(posedge clk_sys) disable iff (!resetn)
    fall && live |-> head.valid == (st.seen == 3'(PIPE_DEPTH));
  endproperty
  a_latency: assert property (p_latency) else $error("Bad latency.");

  property p_range;
    @(posedge clk_sys) disable iff (!resetn)
    sample_valid && range_flag |-> sample_word == CODE_TOP
      || sample_word == CODE_BOTTOM;
  endproperty
  a_range: assert property (p_range) else $error("Bad range code.");

  property p_track;
    @(posedge clk_sys) disable iff (!resetn)
    live && conv_clk ##1 live && !conv_clk |=> $stable(st.track)
      && st.track == DW'($past(diff, 2));
  endproperty
  a_track: assert property (p_track) else $error("Bad hold.");

  c_top: cover property (@(posedge clk_sys) push_if.valid
    && push_if.data == {1'b0, CODE_TOP});
  c_over: cover property (@(posedge clk_sys) sample_valid && range_flag);
  c_full: cover property (@(posedge clk_sys) overrun);
  c_down: cover property (@(posedge clk_sys) shutdown ##1 !shutdown);

endmodule
`default_nettype wire

// ---- dv/capture_partner.sv ----
// Capture-side model: makes the conversion clock and takes results.
// Assumes one clk_sys domain shared with the converter block.
`timescale 1ns/1ps
`default_nettype none
module capture_partner (
  input  wire logic clk_sys,      // System clock.
  input  wire logic resetn,       // Sync reset, low.
  input  wire logic run,          // Run conversion clock.
  input  wire logic stall,        // Random back-pressure.
  input  wire logic hold,         // Refuse every result.
  input  wire logic coin,         // Random bit.
  output var  logic conv_clk,     // Conversion clock.
  output var  logic sample_ready  // Takes a result.
);
  logic [2:0] ph;
  // Four cycles high then four low; the clock stands low when idle.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || !run)
    begin
      ph       <= 3'h0;
      conv_clk <= 1'b0;
    end
    else
    begin
      ph       <= ph + 3'h1;
      conv_clk <= ~ph[2];
    end
    sample_ready <= !hold && !(stall && coin);
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the converter capture block.
// Assumes the capture partner model and the design package.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_capture_pkg::*;
  typedef struct {logic [8:0] e; int n;} note_s;
  logic clk_sys, resetn, conv_clk, power_down_n, sample_ready, prev;
  logic run, stall, hold, sample_valid, range_flag, shutdown, overrun;
  logic signed [11:0] in_p, in_n, trk_p, trk_n;
  logic signed [11:0] tbl [8] = '{12'sd1000, -12'sd1000, 12'sd0,
    12'sd4, 12'sd1001, -12'sd1001, 12'sd1, 12'sd500};
  logic [7:0]  sample_word;
  logic [31:0] lfsr;
  int          mismatches, comparisons, falls, cycles, exact;
  note_s       q[$];
  logic signed [11:0] dq[$];

  adc_sample_capture #(.DW(12)) dut (.clk_sys(clk_sys), .resetn(resetn),
    .conv_clk(conv_clk), .power_down_n(power_down_n),
    .input_positive(in_p), .input_negative(in_n),
    .sample_word(sample_word), .range_flag(range_flag),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .shutdown(shutdown), .overrun(overrun));
  capture_partner partner (.clk_sys(clk_sys), .resetn(resetn), .run(run),
    .stall(stall), .hold(hold), .coin(lfsr[5]), .conv_clk(conv_clk),
    .sample_ready(sample_ready));

  // Ideal transfer: offset binary with clamped range flag.
  function automatic logic [8:0] conv(int d);
    if (d > 1000)
      return 9'h1ff;
    if (d < -1000)
      return 9'h100;
    return {1'b0, 8'((d + 1000) * 255 / 2000)};
  endfunction

  // Next state of the 32-bit stimulus shift register.
  function automatic logic [31:0] lfsr_step(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Compares one value and counts the result.
  task automatic check(string what, logic [11:0] exp, logic [11:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Returns at the first edge of a high conversion phase.
  task automatic rise();
    @(posedge clk_sys);
    while (conv_clk)
      @(posedge clk_sys);
    while (!conv_clk)
      @(posedge clk_sys);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Counts cycles and ends the run when the ceiling is reached.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      mismatches++;
      summarize();
    end
  end

  // Drives inputs, tracks the held value and notes each capture.
  always @(posedge clk_sys)
  begin
    lfsr <= lfsr_step(lfsr);
    in_p <= (conv_clk && dq.size() > 0) ? dq[0] : {lfsr[10], lfsr[10:0]};
    in_n <= (conv_clk && dq.size() > 0) ? 12'sd0 : {lfsr[21], lfsr[21:11]};
    if (resetn && power_down_n && prev && !conv_clk)
    begin
      falls++;
      q.push_back('{conv(int'(trk_p) - int'(trk_n)), falls});
      if (dq.size() > 0)
        dq.delete(0);
    end
    if (conv_clk)
    begin
      trk_p = in_p;
      trk_n = in_n;
    end
    prev = conv_clk;
  end

  // Takes the oldest note whenever a result is handed over.
  always @(negedge clk_sys)
    if (resetn && sample_valid === 1'b1 && sample_ready === 1'b1)
    begin
      if (q.size() == 0)
        check("spare word", 12'h0, 12'h1);
      else
      begin
        check("word", 12'(q[0].e), 12'({range_flag, sample_word}));
        if (exact)
          check("latency", 12'h5, 12'(falls - q[0].n));
        q.delete(0);
      end
    end

  initial
  begin
    resetn = 1'b0;
    power_down_n = 1'b1;
    run = 1'b0;
    stall = 1'b0;
    hold = 1'b0;
    in_p = 12'sd0;
    in_n = 12'sd0;
    lfsr = 32'h97bc;
    exact = 1;
    foreach (tbl[i])
      dq.push_back(tbl[i]);
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    check("idle", 12'h0, {sample_valid, shutdown, overrun, range_flag,
      sample_word});
    @(posedge clk_sys);
    run <= 1'b1;
    repeat (300) @(posedge clk_sys);
    exact = 0;
    stall <= 1'b1;
    repeat (400) @(posedge clk_sys);
    stall <= 1'b0;
    @(negedge clk_sys);
    check("overrun", 12'h0, 12'(overrun));
    rise();
    power_down_n <= 1'b0;
    while (q.size() > 0 && q[$].n > falls - 5)
      q.delete(q.size() - 1);
    repeat (40) @(posedge clk_sys);
    @(negedge clk_sys);
    check("shutdown", 12'h1, 12'(shutdown));
    rise();
    power_down_n <= 1'b1;
    repeat (200) @(posedge clk_sys);
    @(negedge clk_sys);
    check("awake", 12'h0, 12'(shutdown));
    @(posedge clk_sys);
    hold <= 1'b1;
    repeat (120) @(posedge clk_sys);
    @(negedge clk_sys);
    check("overrun", 12'h1, 12'(overrun));
    @(posedge clk_sys);
    run <= 1'b0;
    hold <= 1'b0;
    repeat (30) @(posedge clk_sys);
    @(negedge clk_sys);
    check("drained", 12'h0, 12'(sample_valid));
    summarize();
  end
endmodule
`default_nettype wire
